// ### design/counter_routing_control.sv
// counter clock, gate and output routing with interrupt flags and led control
// assumes an AXI4-Lite master and isolated inputs asynchronous to the clock
`timescale 1ns/10ps
module counter_routing_control #(
	parameter int unsigned DIV_100K = ctr_pkg::TB_DIV_100K,
	parameter int unsigned DIV_10K  = ctr_pkg::TB_DIV_10K,
	parameter int unsigned DIV_1K   = ctr_pkg::TB_DIV_1K,
	parameter int unsigned DIV_100  = ctr_pkg::TB_DIV_100
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic [11:0] i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [11:0] i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	input  wire logic        i_iso_input_zero,
	input  wire logic        i_iso_input_one,
	input  wire logic        i_iso_input_two,
	input  wire logic        i_iso_input_three,
	output logic             o_iso_output_two,
	output logic             o_iso_output_two_routed,
	output logic             o_iso_output_three,
	output logic             o_iso_output_three_routed,
	output logic             o_irq,
	output logic             o_led_enable_a,
	output logic             o_led_enable_b,
	output logic             o_led_enable_c,
	output logic             o_led_enable_d
);
	function automatic logic [9:0] word_index(input logic [11:0] addr);
		word_index = addr[11:2];
	endfunction : word_index

	function automatic logic is_mapped(input logic [9:0] idx);
		case (idx)
			ctr_pkg::IDX_IRQ_FLAG, ctr_pkg::IDX_CNT_FIRST, ctr_pkg::IDX_CNT_SECOND,
			ctr_pkg::IDX_CHIP_CTRL, ctr_pkg::IDX_START_FIRST, ctr_pkg::IDX_START_SECOND,
			ctr_pkg::IDX_SET_FIRST, ctr_pkg::IDX_SET_SECOND, ctr_pkg::IDX_IRQ_MASK,
			ctr_pkg::IDX_LED: is_mapped = 1'b1;
			default:          is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// input synchronisers: meta stage feeds only the sync stage
	logic [3:0] iso_meta;
	logic [3:0] iso_sync;
	logic [3:0] iso_prev;
	logic [3:0] iso_rise;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			iso_meta <= 4'h0;
			iso_sync <= 4'h0;
			iso_prev <= 4'h0;
		end
		else
		begin
			iso_meta <= {i_iso_input_three, i_iso_input_two, i_iso_input_one,
				i_iso_input_zero};
			iso_sync <= iso_meta;
			iso_prev <= iso_sync;
		end
	end

	assign iso_rise = iso_sync & ~iso_prev;

	// register file state; index 0 is the first counter, 1 the second
	logic [1:0]  irq_flag;
	logic [1:0]  irq_mask;
	logic [1:0]  soft_gate;
	logic [1:0]  clk_sel;
	logic [1:0]  gate_sel;
	logic [1:0]  out_route;
	logic [1:0]  irq_en;
	logic [1:0]  tb_sel;
	logic        cascade_enable;
	logic [3:0]  led;
	logic [15:0] reload [2];
	logic [1:0]  load;
	logic [1:0]  out_prev;
	logic [1:0]  next_irq_flag;
	logic [1:0]  next_irq_mask;
	logic [1:0]  next_soft_gate;
	logic [1:0]  next_clk_sel;
	logic [1:0]  next_gate_sel;
	logic [1:0]  next_out_route;
	logic [1:0]  next_irq_en;
	logic [1:0]  next_tb_sel;
	logic        next_cascade_enable;
	logic [3:0]  next_led;
	logic [15:0] next_reload [2];
	logic [1:0]  next_load;

	// write channel state
	typedef enum logic [0:0]
	{
		WR_COLLECT = 1'b0,
		WR_RESP    = 1'b1
	} wr_state_t;

	wr_state_t   wr_state;
	wr_state_t   next_wr_state;
	logic        aw_held;
	logic        w_held;
	logic [9:0]  aw_idx;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_aw_held;
	logic        next_w_held;
	logic [9:0]  next_aw_idx;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic [1:0]  next_bresp;
	logic        do_write;
	logic [7:0]  wb;

	assign o_s_axi_awready = (wr_state == WR_COLLECT) && !aw_held;
	assign o_s_axi_wready  = (wr_state == WR_COLLECT) && !w_held;
	assign o_s_axi_bvalid  = (wr_state == WR_RESP);
	assign do_write        = (wr_state == WR_COLLECT) && aw_held && w_held;
	assign wb              = w_data[7:0];

	// counters and routing
	ctr_if #(.W(ctr_pkg::CNT_W)) cif [2] ();
	logic       tb_tick;
	logic [1:0] ctr_out;
	logic [1:0] out_rise;

	timebase_gen #(
		.DIV_100K (DIV_100K),
		.DIV_10K  (DIV_10K),
		.DIV_1K   (DIV_1K),
		.DIV_100  (DIV_100)
	) u_timebase (
		.i_ref_clk  (i_ref_clk),
		.i_rst_n    (i_rst_n),
		.i_rate_sel (tb_sel),
		.o_tick     (tb_tick)
	);

	assign ctr_out[0] = cif[0].out;
	assign ctr_out[1] = cif[1].out;
	assign out_rise   = ctr_out & ~out_prev;

	assign cif[0].tick = clk_sel[0] ? iso_rise[1] : tb_tick;
	assign cif[1].tick = cascade_enable ? out_rise[0] :
		(clk_sel[1] ? iso_rise[3] : tb_tick);
	assign cif[0].gate = gate_sel[0] ? iso_sync[0] : soft_gate[0];
	assign cif[1].gate = gate_sel[1] ? iso_sync[2] : soft_gate[1];

	for (genvar g = 0; g < 2; g++)
	begin : g_ctr
		assign cif[g].load       = load[g];
		assign cif[g].load_value = reload[g];
		down_counter16 #(
			.W (ctr_pkg::CNT_W)
		) u_ctr (
			.i_ref_clk (i_ref_clk),
			.i_rst_n   (i_rst_n),
			.port      (cif[g])
		);
	end

	// register writes, flag updates
	always_comb
	begin
		next_irq_flag       = irq_flag;
		next_irq_mask       = irq_mask;
		next_soft_gate      = soft_gate;
		next_clk_sel        = clk_sel;
		next_gate_sel       = gate_sel;
		next_out_route      = out_route;
		next_irq_en         = irq_en;
		next_tb_sel         = tb_sel;
		next_cascade_enable = cascade_enable;
		next_led            = led;
		next_reload[0]      = reload[0];
		next_reload[1]      = reload[1];
		next_load           = 2'h0;
		if (do_write && w_strb[0])
		begin
			case (aw_idx)
				ctr_pkg::IDX_IRQ_FLAG:
				begin
					if (wb[ctr_pkg::POS_FLAG_FIRST])
						next_irq_flag[0] = 1'b0;
					if (wb[ctr_pkg::POS_FLAG_SECOND])
						next_irq_flag[1] = 1'b0;
				end
				ctr_pkg::IDX_START_FIRST:  next_soft_gate[0] = wb[ctr_pkg::POS_SOFT_GATE];
				ctr_pkg::IDX_START_SECOND: next_soft_gate[1] = wb[ctr_pkg::POS_SOFT_GATE];
				ctr_pkg::IDX_SET_FIRST:
				begin
					next_clk_sel[0]   = wb[ctr_pkg::POS_CLK_SEL];
					next_gate_sel[0]  = wb[ctr_pkg::POS_GATE_SEL];
					next_out_route[0] = wb[ctr_pkg::POS_OUT_ROUTE];
					next_irq_en[0]    = wb[ctr_pkg::POS_IRQ_EN];
				end
				ctr_pkg::IDX_SET_SECOND:
				begin
					next_clk_sel[1]     = wb[ctr_pkg::POS_CLK_SEL];
					next_gate_sel[1]    = wb[ctr_pkg::POS_GATE_SEL];
					next_out_route[1]   = wb[ctr_pkg::POS_OUT_ROUTE];
					next_irq_en[1]      = wb[ctr_pkg::POS_IRQ_EN];
					next_tb_sel         = {wb[ctr_pkg::POS_TB_HIGH], wb[ctr_pkg::POS_TB_LOW]};
					next_cascade_enable = wb[ctr_pkg::POS_CASCADE];
				end
				ctr_pkg::IDX_IRQ_MASK:
				begin
					next_irq_mask[0] = wb[ctr_pkg::POS_FLAG_FIRST];
					next_irq_mask[1] = wb[ctr_pkg::POS_FLAG_SECOND];
				end
				ctr_pkg::IDX_LED: next_led = wb[3:0];
				default: ;
			endcase
		end
		if (do_write && (aw_idx == ctr_pkg::IDX_CNT_FIRST || aw_idx == ctr_pkg::IDX_CNT_SECOND)
			&& |w_strb[1:0])
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (aw_idx == (ctr_pkg::IDX_CNT_FIRST + 10'(i)))
				begin
					if (w_strb[0])
						next_reload[i][7:0] = w_data[7:0];
					if (w_strb[1])
						next_reload[i][15:8] = w_data[15:8];
					if (next_reload[i] < ctr_pkg::CNT_MIN)
						next_reload[i] = ctr_pkg::CNT_MIN;
					next_load[i] = 1'b1;
				end
			end
		end
		// set after clear, so a same-cycle event is kept
		for (int i = 0; i < 2; i++)
		begin
			if (irq_en[i] && out_rise[i])
				next_irq_flag[i] = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			irq_flag       <= ctr_pkg::RST_FLAGS;
			irq_mask       <= ctr_pkg::RST_MASK;
			soft_gate      <= ctr_pkg::RST_SEL;
			clk_sel        <= ctr_pkg::RST_SEL;
			gate_sel       <= ctr_pkg::RST_SEL;
			out_route      <= ctr_pkg::RST_SEL;
			irq_en         <= ctr_pkg::RST_SEL;
			tb_sel         <= ctr_pkg::RST_TB;
			cascade_enable <= 1'b0;
			led            <= ctr_pkg::RST_LED;
			reload[0]      <= ctr_pkg::RST_RELOAD;
			reload[1]      <= ctr_pkg::RST_RELOAD;
			load           <= 2'h0;
			out_prev       <= 2'h3;
		end
		else
		begin
			irq_flag       <= next_irq_flag;
			irq_mask       <= next_irq_mask;
			soft_gate      <= next_soft_gate;
			clk_sel        <= next_clk_sel;
			gate_sel       <= next_gate_sel;
			out_route      <= next_out_route;
			irq_en         <= next_irq_en;
			tb_sel         <= next_tb_sel;
			cascade_enable <= next_cascade_enable;
			led            <= next_led;
			reload[0]      <= next_reload[0];
			reload[1]      <= next_reload[1];
			load           <= next_load;
			out_prev       <= ctr_out;
		end
	end

	// write address and data in either order, then one response
	always_comb
	begin
		next_wr_state = wr_state;
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_aw_idx   = aw_idx;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bresp    = o_s_axi_bresp;
		if (o_s_axi_awready && i_s_axi_awvalid)
		begin
			next_aw_held = 1'b1;
			next_aw_idx  = word_index(i_s_axi_awaddr);
		end
		if (o_s_axi_wready && i_s_axi_wvalid)
		begin
			next_w_held = 1'b1;
			next_w_data = i_s_axi_wdata;
			next_w_strb = i_s_axi_wstrb;
		end
		case (wr_state)
			WR_COLLECT:
			begin
				if (do_write)
				begin
					next_aw_held  = 1'b0;
					next_w_held   = 1'b0;
					next_bresp    = is_mapped(aw_idx) ? ctr_pkg::RESP_OKAY : ctr_pkg::RESP_SLVERR;
					next_wr_state = WR_RESP;
				end
			end
			WR_RESP:
			begin
				if (i_s_axi_bready)
					next_wr_state = WR_COLLECT;
			end
			default: next_wr_state = WR_COLLECT;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_state      <= WR_COLLECT;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_idx        <= 10'h000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			o_s_axi_bresp <= ctr_pkg::RESP_OKAY;
		end
		else
		begin
			wr_state      <= next_wr_state;
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_idx        <= next_aw_idx;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			o_s_axi_bresp <= next_bresp;
		end
	end

	// read channel
	logic [31:0] rd_word;
	logic [9:0]  rd_idx;
	logic        next_rvalid;

	assign o_s_axi_arready = !o_s_axi_rvalid;
	assign rd_idx          = word_index(i_s_axi_araddr);

	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (rd_idx)
			ctr_pkg::IDX_IRQ_FLAG:
			begin
				rd_word[ctr_pkg::POS_FLAG_FIRST]  = irq_flag[0];
				rd_word[ctr_pkg::POS_FLAG_SECOND] = irq_flag[1];
			end
			ctr_pkg::IDX_CNT_FIRST:  rd_word[15:0] = cif[0].count;
			ctr_pkg::IDX_CNT_SECOND: rd_word[15:0] = cif[1].count;
			ctr_pkg::IDX_START_FIRST, ctr_pkg::IDX_START_SECOND:
			begin
				rd_word[ctr_pkg::POS_SOFT_GATE]  = soft_gate[rd_idx[0]];
				rd_word[ctr_pkg::POS_OUT_STATUS] = ctr_out[rd_idx[0]];
			end
			ctr_pkg::IDX_SET_FIRST, ctr_pkg::IDX_SET_SECOND:
			begin
				rd_word[ctr_pkg::POS_CLK_SEL]   = clk_sel[rd_idx[0]];
				rd_word[ctr_pkg::POS_GATE_SEL]  = gate_sel[rd_idx[0]];
				rd_word[ctr_pkg::POS_OUT_ROUTE] = out_route[rd_idx[0]];
				rd_word[ctr_pkg::POS_IRQ_EN]    = irq_en[rd_idx[0]];
				if (rd_idx[0])
				begin
					rd_word[ctr_pkg::POS_TB_LOW]  = tb_sel[0];
					rd_word[ctr_pkg::POS_TB_HIGH] = tb_sel[1];
					rd_word[ctr_pkg::POS_CASCADE] = cascade_enable;
				end
			end
			ctr_pkg::IDX_IRQ_MASK:
			begin
				rd_word[ctr_pkg::POS_FLAG_FIRST]  = irq_mask[0];
				rd_word[ctr_pkg::POS_FLAG_SECOND] = irq_mask[1];
			end
			ctr_pkg::IDX_LED: rd_word[3:0] = led;
			default: rd_word = 32'h0000_0000;
		endcase
		next_rvalid = o_s_axi_rvalid ? !i_s_axi_rready : i_s_axi_arvalid;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= 32'h0000_0000;
			o_s_axi_rresp  <= ctr_pkg::RESP_OKAY;
		end
		else
		begin
			o_s_axi_rvalid <= next_rvalid;
			if (o_s_axi_arready && i_s_axi_arvalid)
			begin
				o_s_axi_rdata <= rd_word;
				o_s_axi_rresp <= is_mapped(rd_idx) ? ctr_pkg::RESP_OKAY : ctr_pkg::RESP_SLVERR;
			end
		end
	end

	// registered outputs
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_iso_output_two          <= 1'b0;
			o_iso_output_three        <= 1'b0;
			o_iso_output_two_routed   <= 1'b0;
			o_iso_output_three_routed <= 1'b0;
			o_irq                     <= 1'b0;
			{o_led_enable_a, o_led_enable_b, o_led_enable_c, o_led_enable_d} <= 4'h0;
		end
		else
		begin
			o_iso_output_two          <= out_route[0] & ctr_out[0];
			o_iso_output_three        <= out_route[1] & ctr_out[1];
			o_iso_output_two_routed   <= out_route[0];
			o_iso_output_three_routed <= out_route[1];
			o_irq                     <= |(irq_flag & irq_mask);
			{o_led_enable_a, o_led_enable_b, o_led_enable_c, o_led_enable_d} <= led;
		end
	end
endmodule : counter_routing_control

// ### include/ctr_pkg.sv
// shared constants for the counter routing block
// assumes a 125 MHz reference clock and a 32-bit register bus
package ctr_pkg;
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned TB_100K_HZ   = 100_000;
	localparam int unsigned TB_10K_HZ    = 10_000;
	localparam int unsigned TB_1K_HZ     = 1_000;
	localparam int unsigned TB_100_HZ    = 100;
	localparam int unsigned TB_DIV_100K  = CLK_HZ / TB_100K_HZ;
	localparam int unsigned TB_DIV_10K   = CLK_HZ / TB_10K_HZ;
	localparam int unsigned TB_DIV_1K    = CLK_HZ / TB_1K_HZ;
	localparam int unsigned TB_DIV_100   = CLK_HZ / TB_100_HZ;

	localparam int unsigned ADDR_W       = 12;
	localparam int unsigned IDX_W        = 10;
	localparam int unsigned CNT_W        = 16;
	localparam logic [15:0] CNT_MIN      = 16'h0002;

	// register indices; byte address is four times the index
	localparam logic [9:0]  IDX_IRQ_FLAG   = 10'h207;
	localparam logic [9:0]  IDX_CNT_FIRST  = 10'h208;
	localparam logic [9:0]  IDX_CNT_SECOND = 10'h209;
	localparam logic [9:0]  IDX_CHIP_CTRL  = 10'h20b;
	localparam logic [9:0]  IDX_START_FIRST  = 10'h20c;
	localparam logic [9:0]  IDX_START_SECOND = 10'h20d;
	localparam logic [9:0]  IDX_SET_FIRST  = 10'h20e;
	localparam logic [9:0]  IDX_SET_SECOND = 10'h20f;
	localparam logic [9:0]  IDX_IRQ_MASK   = 10'h210;
	localparam logic [9:0]  IDX_LED        = 10'h212;

	// field positions
	localparam int unsigned POS_FLAG_FIRST  = 2;
	localparam int unsigned POS_FLAG_SECOND = 3;
	localparam int unsigned POS_SOFT_GATE   = 0;
	localparam int unsigned POS_OUT_STATUS  = 4;
	localparam int unsigned POS_CLK_SEL     = 0;
	localparam int unsigned POS_GATE_SEL    = 1;
	localparam int unsigned POS_OUT_ROUTE   = 2;
	localparam int unsigned POS_IRQ_EN      = 3;
	localparam int unsigned POS_TB_LOW      = 5;
	localparam int unsigned POS_TB_HIGH     = 6;
	localparam int unsigned POS_CASCADE     = 7;

	// reset values
	localparam logic [1:0]  RST_FLAGS   = 2'h0;
	localparam logic [1:0]  RST_MASK    = 2'h3;
	localparam logic [1:0]  RST_SEL     = 2'h0;
	localparam logic [1:0]  RST_TB      = 2'h0;
	localparam logic [3:0]  RST_LED     = 4'h0;
	localparam logic [15:0] RST_RELOAD  = 16'hffff;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		TB_100K = 2'b00,
		TB_10K  = 2'b01,
		TB_1K   = 2'b10,
		TB_100  = 2'b11
	} tb_rate_t;
endpackage : ctr_pkg

// ### include/ctr_if.sv
// signals between the routing logic and one down counter
// assumes both ends run on the same reference clock
`timescale 1ns/10ps
interface ctr_if #(parameter int unsigned W = 16);
	logic         tick;
	logic         gate;
	logic         load;
	logic [W-1:0] load_value;
	logic [W-1:0] count;
	logic         out;
	modport ctl (output tick, gate, load, load_value, input count, out);
	modport cnt (input tick, gate, load, load_value, output count, out);
endinterface : ctr_if

// ### design/timebase_gen.sv
// internal time base: one-cycle tick at one of four selectable rates
// assumes the rate select is a registered level
`timescale 1ns/10ps
module timebase_gen #(
	parameter int unsigned DIV_100K = ctr_pkg::TB_DIV_100K,
	parameter int unsigned DIV_10K  = ctr_pkg::TB_DIV_10K,
	parameter int unsigned DIV_1K   = ctr_pkg::TB_DIV_1K,
	parameter int unsigned DIV_100  = ctr_pkg::TB_DIV_100
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic [1:0] i_rate_sel,
	output logic            o_tick
);
	localparam int unsigned DW = $clog2(DIV_100 + 1);
	logic [DW-1:0] div_cnt;
	logic [DW-1:0] next_div_cnt;
	logic [DW-1:0] limit;

	if (DIV_100K < 2 || DIV_10K < DIV_100K || DIV_1K < DIV_10K || DIV_100 < DIV_1K)
	begin : g_check
		$error("time base divisors must be at least 2 and rise with slower rates");
	end

	always_comb
	begin
		case (ctr_pkg::tb_rate_t'(i_rate_sel))
			ctr_pkg::TB_100K: limit = DW'(DIV_100K - 1);
			ctr_pkg::TB_10K:  limit = DW'(DIV_10K - 1);
			ctr_pkg::TB_1K:   limit = DW'(DIV_1K - 1);
			ctr_pkg::TB_100:  limit = DW'(DIV_100 - 1);
			default:          limit = DW'(DIV_100K - 1);
		endcase
		next_div_cnt = (div_cnt >= limit) ? '0 : div_cnt + 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			div_cnt <= '0;
			o_tick  <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			o_tick  <= (div_cnt >= limit);
		end
	end
endmodule : timebase_gen

// ### design/down_counter16.sv
// down counter in rate mode: output low while the count sits at one
// assumes tick is a one-cycle enable and load a one-cycle strobe
`timescale 1ns/10ps
module down_counter16 #(
	parameter int unsigned W = ctr_pkg::CNT_W
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	ctr_if.cnt        port
);
	logic [W-1:0] reload;
	logic [W-1:0] next_reload;
	logic [W-1:0] next_count;

	if (W < 2)
	begin : g_check
		$error("counter width must be at least 2");
	end

	always_comb
	begin
		next_reload = reload;
		next_count  = port.count;
		if (port.load)
		begin
			next_reload = port.load_value;
			next_count  = port.load_value;
		end
		else if (port.tick && port.gate)
		begin
			next_count = (port.count <= W'(1)) ? reload : port.count - 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			reload     <= '1;
			port.count <= '1;
			port.out   <= 1'b1;
		end
		else
		begin
			reload     <= next_reload;
			port.count <= next_count;
			port.out   <= (next_count != W'(1));
		end
	end
endmodule : down_counter16

// ### tb/crc_chk.sv
// port assertions for the counter routing block
// assumes it is bound into counter_routing_control
`timescale 1ns/10ps
module crc_chk (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        i_s_axi_awvalid,
	input wire logic        o_s_axi_awready,
	input wire logic        i_s_axi_wvalid,
	input wire logic        o_s_axi_wready,
	input wire logic [1:0]  o_s_axi_bresp,
	input wire logic        o_s_axi_bvalid,
	input wire logic        i_s_axi_bready,
	input wire logic        i_s_axi_arvalid,
	input wire logic        o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0]  o_s_axi_rresp,
	input wire logic        o_s_axi_rvalid,
	input wire logic        i_s_axi_rready,
	input wire logic        o_iso_output_two,
	input wire logic        o_iso_output_two_routed,
	input wire logic        o_iso_output_three,
	input wire logic        o_iso_output_three_routed,
	input wire logic        o_irq
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	chk_two_unrouted:
	assert property (!o_iso_output_two_routed && !$past(o_iso_output_two_routed)
		|-> !o_iso_output_two) else $error("output two driven unrouted");
	chk_three_unrouted:
	assert property (!o_iso_output_three_routed && !$past(o_iso_output_three_routed)
		|-> !o_iso_output_three) else $error("output three driven unrouted");
	chk_b_hold:
	assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped");
	chk_r_hold:
	assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data dropped");
	chk_b_busy:
	assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while response pending");
	chk_r_busy:
	assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read taken while busy");
	chk_rd_latency:
	assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read answer late");
	chk_wr_latency:
	assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
		|-> ##2 o_s_axi_bvalid) else $error("write answer late");
	chk_b_once:
	assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
		else $error("write response repeated");
	cover property ($rose(o_irq));
	cover property ($fell(o_iso_output_three));
	cover property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2);
endmodule : crc_chk
bind counter_routing_control crc_chk u_chk (.*);

// ### tb/iso_field_model.sv
// field side: square wave on the clock inputs, level on the gate inputs
// assumes the bench starts and stops the wave; it stands low when stopped
`timescale 1ns/10ps
module iso_field_model #(
	parameter int unsigned HALF = 5
) (
	input  wire logic i_ref_clk,
	input  wire logic i_run,
	input  wire logic i_gate,
	output logic      o_gate,
	output logic      o_wave
);
	int n = 0;
	always @(posedge i_ref_clk)
	begin
		n <= (n == HALF - 1) ? 0 : n + 1;
		if (!i_run)
			o_wave <= 1'h0;
		else if (n == HALF - 1)
			o_wave <= !o_wave;
	end
	assign o_gate = i_gate;
endmodule : iso_field_model

// ### tb/counter_routing_control_tb.sv
// self-checking bench for the counter routing block
// assumes the small time base dividers 4/8/16/32
`timescale 1ns/10ps
module counter_routing_control_tb;
	logic        clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
	logic        arv = 1'h0, rready = 1'h0, run = 1'h0, gate = 1'h0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [31:0] seed = 32'h3b9a4e5c;
	logic [1:0]  bresp, rresp;
	logic        aw_rdy, w_rdy, bv, ar_rdy, rv, g, w, o2, o2r, o3, o3r, irq, la, lb, lc, ld;
	int          err_count = 0, comparisons = 0, n;
	counter_routing_control #(.DIV_100K(4), .DIV_10K(8), .DIV_1K(16), .DIV_100(32)) u_dut (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv),
		.o_s_axi_awready(aw_rdy), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
		.i_s_axi_wvalid(wv), .o_s_axi_wready(w_rdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(ar_rdy), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rready), .i_iso_input_zero(g),
		.i_iso_input_one(w), .i_iso_input_two(g), .i_iso_input_three(w),
		.o_iso_output_two(o2), .o_iso_output_two_routed(o2r), .o_iso_output_three(o3),
		.o_iso_output_three_routed(o3r), .o_irq(irq), .o_led_enable_a(la), .o_led_enable_b(lb),
		.o_led_enable_c(lc), .o_led_enable_d(ld));
	iso_field_model u_field (.i_ref_clk(clk), .i_run(run), .i_gate(gate), .o_gate(g), .o_wave(w));
	initial forever #4 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// cycles between output rises: reload times divider
	function automatic int per_of(input int r, input int rl);
		return rl * (4 << r);
	endfunction : per_of
	task automatic end_sim();
		$display("counts: %0d compares, %0d errors", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] gt, input logic [31:0] x);
		comparisons++;
		if (gt !== x)
		begin
			err_count++;
			$display("Error at %0t got %h expected %h", $time, gt, x);
		end
	endtask : chk
	task automatic to();
		chk(32'h0, 32'h1);
		end_sim();
	endtask : to
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		{awaddr, wdata, awv, wv, bready} <= {a, 2'h0, d, 3'h7};
		for (n = 0; !(bv && bready); n++)
		begin
			@(posedge clk);
			if (n > 60) to();
			if (aw_rdy) awv <= 1'h0;
			if (w_rdy) wv <= 1'h0;
		end
		bready <= 1'h0;
		chk(bresp, e);
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [31:0] x, input logic [1:0] e);
		@(posedge clk);
		{araddr, arv, rready} <= {a, 2'h0, 2'h3};
		for (n = 0; !(rv && rready); n++)
		begin
			@(posedge clk);
			if (n > 60) to();
			if (ar_rdy) arv <= 1'h0;
		end
		rready <= 1'h0;
		chk(rresp, e);
		chk(rdata, x);
	endtask : rd
	task automatic per(input int x);
		int t[4];
		int c;
		logic p;
		c = 0;
		p = 1'h1;
		for (n = 0; c < 3; n++)
		begin
			@(posedge clk);
			if (n > 4000) to();
			if (o3 && !p)
			begin
				c++;
				t[c] = n;
			end
			p = o3;
		end
		chk(t[3] - t[2], x);
	endtask : per
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		rd(10'h207, 32'h0, 2'h0);
		rd(10'h20c, 32'h10, 2'h0);
		rd(10'h20e, 32'h0, 2'h0);
		rd(10'h20f, 32'h0, 2'h0);
		rd(10'h210, 32'hc, 2'h0);
		rd(10'h208, 32'hffff, 2'h0);
		rd(10'h3ff, 32'h0, 2'h2);
		wr(10'h3ff, rnd(), 2'h2);
		repeat (4)
		begin
			v = rnd();
			wr(10'h212, v, 2'h0);
			rd(10'h212, {28'h0, v[3:0]}, 2'h0);
			chk({la, lb, lc, ld}, v[3:0]);
		end
		$display("test map and leds done");
		wr(10'h208, 32'h3, 2'h0);
		wr(10'h20e, 32'hf, 2'h0);
		run <= 1'h1;
		gate <= 1'h1;
		for (n = 0; !irq; n++)
		begin
			if (n > 400) to();
			@(posedge clk);
		end
		chk(o2r, 1'h1);
		chk(o2, 1'h1);
		run <= 1'h0;
		rd(10'h207, 32'h4, 2'h0);
		wr(10'h207, 32'h0, 2'h0);
		rd(10'h207, 32'h4, 2'h0);
		wr(10'h210, 32'h0, 2'h0);
		rd(10'h210, 32'h0, 2'h0);
		chk(irq, 1'h0);
		wr(10'h210, 32'hc, 2'h0);
		wr(10'h207, 32'h4, 2'h0);
		rd(10'h207, 32'h0, 2'h0);
		chk(irq, 1'h0);
		wr(10'h20e, 32'h7, 2'h0);
		run <= 1'h1;
		repeat (100) @(posedge clk);
		rd(10'h207, 32'h0, 2'h0);
		$display("test interrupt done");
		wr(10'h209, 32'h2, 2'h0);
		wr(10'h20f, 32'hf, 2'h0);
		per(20);
		chk(o3r, 1'h1);
		run <= 1'h0;
		wr(10'h20e, 32'h0, 2'h0);
		wr(10'h20d, 32'h1, 2'h0);
		chk(o2, 1'h0);
		for (int r = 0; r < 4; r++)
		begin
			wr(10'h20f, 32'h4 | (r << 5), 2'h0);
			per(per_of(r, 2));
		end
		wr(10'h208, 32'h2, 2'h0);
		wr(10'h20c, 32'h1, 2'h0);
		wr(10'h20f, 32'h84, 2'h0);
		per(per_of(0, 4));
		$display("test rates and cascade done");
		end_sim();
	end
endmodule : counter_routing_control_tb
